// [logic/pcs_regs.sv]
/*
 * Port PHY control and status register bank with bank select.
 * Assumes PHY status inputs and LED drive come from logic on clk.
 */
// Function
// R1: LED blank bit drives all LEDs high
// R2: Transmit disable bit turns transmitter off
// R3: Writing restart bit restarts negotiation
// R4: Crossover disable bit stops automatic crossover
// R5: Force bit selects MDI-X when auto off
// R6: Negotiation enable resets to one
// R7: Advertise 100 full duplex when set
// R8: Advertise 100 half duplex when set
// R9: Advertise 10 full duplex when set
// R10: Advertise 10 half duplex when set
// R11: Status register at bank 49 offset 4
// R12: Status bit 15 selects crossover variant
// R13: Bit 13 shows reversed receive polarity
// R14: Bit 12 shows receive flow control
// R15: Bit 11 shows transmit flow control
// R16: Bit 10 shows link speed
// R17: Bit 9 shows link duplex
// R18: Bit 4 shows partner pause ability
// R19: Bits 3..0 show partner abilities
// R20: Banks 50..63 reserved except bank select
// R21: Live crossover, done, link; flag link change
// R22: Power down bit puts PHY low power
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // PHY status
    input wire logic polarity_rev,
    input wire logic rx_fc_active,
    input wire logic tx_fc_active,
    input wire logic speed_100,
    input wire logic duplex_full,
    input wire logic mdi_status,
    input wire logic negotiation_complete,
    input wire logic link_good,
    input wire logic partner_pause,
    input wire logic [3:0] partner_abil,
    // LED drive from the LED logic
    input wire logic [3:0] led_drive,
    // LED pins
    output logic port_led_out_0,
    output logic port_led_out_1,
    output logic port_led_out_2,
    output logic port_led_out_3,
    // PHY control
    output logic tx_disable,
    output logic power_down,
    output logic auto_negotiation,
    output logic negotiation_restart,
    output logic forced_speed_100,
    output logic forced_duplex_full,
    output logic [3:0] advertise,
    output logic auto_crossover_en,
    output logic force_mdix,
    output logic crossover_variant_select
);

    pcs_pkg::pcs_state_t st;
    pcs_pkg::pcs_state_t next_st;

    // Bank 49 register hit
    function automatic logic hit(
        input logic [5:0] bank,
        input logic [3:0] a,
        input logic [3:0] off
    );
        hit = (bank == `PCS_BANK_PHY) && (a == off);
    endfunction : hit

    function automatic logic [15:0] stat_word(
        input logic xvar
    );
        logic [15:0] w;
        w = 16'h0000;
        w[`PCS_S_XVAR] = xvar;                      // R12
        w[`PCS_S_POL] = polarity_rev;               // R13
        w[`PCS_S_RXFC] = rx_fc_active;              // R14
        w[`PCS_S_TXFC] = tx_fc_active;              // R15
        w[`PCS_S_SPD] = speed_100;                  // R16
        w[`PCS_S_DUP] = duplex_full;                // R17
        w[`PCS_S_MDI] = mdi_status;                 // R21
        w[`PCS_S_DONE] = negotiation_complete;      // R21
        w[`PCS_S_LINK] = link_good;                 // R21
        w[`PCS_S_PAUSE] = partner_pause;            // R18
        w[`PCS_ADV_HI:0] = partner_abil;            // R19
        stat_word = w;
    endfunction : stat_word

    // Offsets that decode to a register in the status bank
    function automatic logic mapped(
        input logic [3:0] a
    );
        mapped = (a == `PCS_OFF_CTRL) || (a == `PCS_OFF_STAT)
            || (a == `PCS_OFF_EVT) || (a == `PCS_OFF_BSEL);
    endfunction : mapped

    always_comb begin
        logic clr_link;
        clr_link = 1'b0;
        next_st = st;
        next_st.restart = 1'b0;
        next_st.rdata = 16'h0000;
        if (wr) begin
            // Bank select reachable from every bank, reserved ones too
            if (addr == `PCS_OFF_BSEL) begin
                next_st.bank = wdata[`PCS_BSEL_HI:0]; // R20
            end
            if (hit(st.bank, addr, `PCS_OFF_CTRL)) begin
                next_st.ctrl = wdata & `PCS_CTRL_WMASK;
                next_st.restart = wdata[`PCS_C_RESTART]; // R3
            end
            if (hit(st.bank, addr, `PCS_OFF_STAT)) begin
                next_st.xvar = wdata[`PCS_S_XVAR];  // R12
            end
            if (hit(st.bank, addr, `PCS_OFF_EVT)) begin
                clr_link = wdata[`PCS_E_LINK];
            end
        end
        if (rd) begin
            if (addr == `PCS_OFF_BSEL) begin
                next_st.rdata = {10'h000, st.bank}; // R20
            end else if (hit(st.bank, addr, `PCS_OFF_CTRL)) begin
                next_st.rdata = st.ctrl;
            end else if (hit(st.bank, addr, `PCS_OFF_STAT)) begin
                next_st.rdata = stat_word(st.xvar); // R11
            end else if (hit(st.bank, addr, `PCS_OFF_EVT)) begin
                next_st.rdata = {15'h0000, st.link_chg};
            end
        end
        // A change in the clearing cycle still lands
        next_st.link_prev = link_good;
        next_st.link_chg = (st.link_chg & ~clr_link)
            | (link_good ^ st.link_prev);           // R21
        next_st.auto_x = ~next_st.ctrl[`PCS_C_XO_DIS]; // R4
        next_st.force_x = next_st.ctrl[`PCS_C_XO_DIS]
            & next_st.ctrl[`PCS_C_FORCE_X];         // R5
        for (int i = 0; i < 4; i++) begin
            // Pin high means LED dark; blanking lands with the control write
            next_st.leds[i] = next_st.ctrl[`PCS_C_LED_OFF] | led_drive[i]; // R1
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.ctrl <= `PCS_CTRL_RST;               // R6
            st.xvar <= `PCS_XVAR_RST;               // R12
            st.bank <= `PCS_BSEL_RST;
            st.link_prev <= 1'b0;
            st.link_chg <= 1'b0;
            st.restart <= 1'b0;
            st.auto_x <= `PCS_XO_AUTO_RST;
            st.force_x <= 1'b0;
            st.leds <= `PCS_LEDS_OFF;
            st.rdata <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign port_led_out_0 = st.leds[0];
    assign port_led_out_1 = st.leds[1];
    assign port_led_out_2 = st.leds[2];
    assign port_led_out_3 = st.leds[3];
    assign tx_disable = st.ctrl[`PCS_C_TX_DIS];     // R2
    assign power_down = st.ctrl[`PCS_C_PWR_DN];     // R22
    assign auto_negotiation = st.ctrl[`PCS_C_AN_EN]; // R6
    assign negotiation_restart = st.restart;        // R3
    // Used only while negotiation is off
    assign forced_speed_100 = st.ctrl[`PCS_C_SPD100];
    assign forced_duplex_full = st.ctrl[`PCS_C_FULL];
    assign advertise = st.ctrl[`PCS_ADV_HI:0];      // R7 R8 R9 R10
    assign auto_crossover_en = st.auto_x;           // R4
    assign force_mdix = st.force_x;                 // R5
    assign crossover_variant_select = st.xvar;      // R12

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence ctrl_wr;
        wr && hit(st.bank, addr, `PCS_OFF_CTRL);
    endsequence

    sequence stat_rd;
        rd && addr != `PCS_OFF_BSEL && hit(st.bank, addr, `PCS_OFF_STAT);
    endsequence

    // Bus shapes shared by the checks below
    sequence ctrl_rd;
        rd && hit(st.bank, addr, `PCS_OFF_CTRL);
    endsequence

    sequence evt_rd;
        rd && hit(st.bank, addr, `PCS_OFF_EVT);
    endsequence

    sequence evt_clr;
        wr && hit(st.bank, addr, `PCS_OFF_EVT) && wdata[`PCS_E_LINK];
    endsequence

    sequence stat_wr;
        wr && hit(st.bank, addr, `PCS_OFF_STAT);
    endsequence

    chk_led_blank: assert property ( // R1
        st.ctrl[`PCS_C_LED_OFF] |-> (port_led_out_0 && port_led_out_1
            && port_led_out_2 && port_led_out_3)
    ) else $error("LEDs not blanked");

    // First cycle after reset still shows the reset level on the pins
    chk_led_follow: assert property ( // R1
        !st.ctrl[`PCS_C_LED_OFF] && !$past(rst) |-> {port_led_out_3, port_led_out_2,
            port_led_out_1, port_led_out_0} == $past(led_drive)
    ) else $error("LEDs do not follow drive");

    chk_tx_disable: assert property ( // R2
        ctrl_wr |=> tx_disable == $past(wdata[`PCS_C_TX_DIS])
    ) else $error("Transmit disable not taken");

    chk_restart_pulse: assert property ( // R3
        ctrl_wr ##0 wdata[`PCS_C_RESTART] ##1 !wr |-> negotiation_restart ##1 !negotiation_restart
    ) else $error("Restart pulse wrong");

    chk_restart_cause: assert property ( // R3
        negotiation_restart |-> $past(wr && addr == `PCS_OFF_CTRL
            && st.bank == `PCS_BANK_PHY && wdata[`PCS_C_RESTART])
    ) else $error("Restart without write");

    chk_restart_only: assert property ( // R3
        !(wr && hit(st.bank, addr, `PCS_OFF_CTRL) && wdata[`PCS_C_RESTART]) |=> !negotiation_restart
    ) else $error("Restart pulse without request");

    chk_auto_xover: assert property ( // R4
        ctrl_wr |=> auto_crossover_en == !$past(wdata[`PCS_C_XO_DIS])
    ) else $error("Crossover enable wrong");

    chk_force_mdix: assert property ( // R5
        force_mdix |-> !auto_crossover_en && st.ctrl[`PCS_C_FORCE_X]
    ) else $error("Forced MDI-X with auto on");

    chk_an_enable: assert property ( // R6
        ctrl_wr ##0 !wdata[`PCS_C_AN_EN] |=> !auto_negotiation
    ) else $error("Negotiation not disabled");

    chk_advertise: assert property ( // R7 R8 R9 R10
        ctrl_wr |=> advertise == $past(wdata[3:0])
    ) else $error("Advertised abilities wrong");

    chk_status_read: assert property ( // R11 R13 R14 R15 R16 R17 R18 R19
        stat_rd |=> rdata[13:0] == {$past(polarity_rev), $past(rx_fc_active),
            $past(tx_fc_active), $past(speed_100), $past(duplex_full), 1'b0,
            $past(mdi_status), $past(negotiation_complete), $past(link_good),
            $past(partner_pause), $past(partner_abil)}
    ) else $error("Status word mismatch");

    chk_xover_variant: assert property ( // R12
        stat_rd |=> rdata[`PCS_S_XVAR] == crossover_variant_select
    ) else $error("Variant bit mismatch");

    chk_rsv_bank: assert property ( // R20
        rd && st.bank >= `PCS_BANK_RSV_LO && addr != `PCS_OFF_BSEL |=> rdata == 16'h0000
    ) else $error("Reserved bank not zero");

    chk_bank_sel: assert property ( // R20
        wr && addr == `PCS_OFF_BSEL ##1 rd && addr == `PCS_OFF_BSEL
            |=> rdata[5:0] == $past(wdata[5:0], 2)
    ) else $error("Bank select lost");

    chk_link_flag: assert property ( // R21
        link_good != st.link_prev |=> st.link_chg
    ) else $error("Link change not flagged");

    chk_power_down: assert property ( // R22
        ctrl_wr |=> power_down == $past(wdata[`PCS_C_PWR_DN])
    ) else $error("Power down not taken");

    chk_rd_only_once: assert property (
        !rd |=> rdata == 16'h0000
    ) else $error("Read data outside read window");

    chk_force_wr: assert property ( // R5
        ctrl_wr |=> force_mdix == $past(wdata[`PCS_C_XO_DIS] && wdata[`PCS_C_FORCE_X])
    ) else $error("Forced MDI-X not taken");

    chk_an_on: assert property ( // R6
        ctrl_wr ##0 wdata[`PCS_C_AN_EN] |=> auto_negotiation
    ) else $error("Negotiation not enabled");

    chk_forced_mode: assert property ( // R6
        ctrl_wr |=> forced_speed_100 == $past(wdata[`PCS_C_SPD100])
            && forced_duplex_full == $past(wdata[`PCS_C_FULL])
    ) else $error("Forced speed or duplex wrong");

    chk_ctrl_hold: assert property ( // R2 R22
        !(wr && hit(st.bank, addr, `PCS_OFF_CTRL)) |=> $stable(st.ctrl)
    ) else $error("Control changed without write");

    chk_ctrl_read: assert property ( // R3
        ctrl_rd |=> rdata == $past(st.ctrl) && !rdata[`PCS_C_RESTART]
    ) else $error("Control read wrong");

    chk_variant_wr: assert property ( // R12
        stat_wr |=> crossover_variant_select == $past(wdata[`PCS_S_XVAR])
    ) else $error("Variant write not taken");

    chk_xvar_hold: assert property ( // R12
        !(wr && hit(st.bank, addr, `PCS_OFF_STAT)) |=> $stable(crossover_variant_select)
    ) else $error("Variant changed without write");

    chk_unmapped: assert property ( // R11
        rd && st.bank == `PCS_BANK_PHY && !mapped(addr) |=> rdata == 16'h0000
    ) else $error("Unmapped offset not zero");

    chk_bsel_wr: assert property ( // R20
        wr && addr == `PCS_OFF_BSEL |=> st.bank == $past(wdata[`PCS_BSEL_HI:0])
    ) else $error("Bank select write lost");

    chk_bsel_rd: assert property ( // R20
        rd && addr == `PCS_OFF_BSEL |=> rdata == {10'h000, $past(st.bank)}
    ) else $error("Bank select read wrong");

    // Only the bank select may change while another bank is selected
    chk_rsv_write: assert property ( // R20
        wr && st.bank != `PCS_BANK_PHY |=> $stable(st.ctrl) && $stable(st.xvar)
    ) else $error("Write outside bank taken");

    chk_evt_read: assert property ( // R21
        evt_rd |=> rdata == {15'h0, $past(st.link_chg)}
    ) else $error("Event read wrong");

    chk_link_clear: assert property ( // R21
        evt_clr ##0 link_good == st.link_prev |=> !st.link_chg
    ) else $error("Link change not cleared");

endmodule : pcs_regs

// [inc/pcs_defs.svh]
/*
 * Constants for the port PHY control and status register bank.
 * Assumes inclusion by bare name from the design file only; the package does not include it.
 */
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_BANK_PHY 6'h31
`define PCS_BANK_RSV_LO 6'h32
`define PCS_OFF_CTRL 4'h2
`define PCS_OFF_STAT 4'h4
`define PCS_OFF_EVT 4'h6
`define PCS_OFF_BSEL 4'he

`define PCS_CTRL_RST 16'h007f
`define PCS_CTRL_WMASK 16'hc77f
`define PCS_BSEL_RST 6'h00
`define PCS_XVAR_RST 1'b1

`define PCS_C_LED_OFF 15
`define PCS_C_TX_DIS 14
`define PCS_C_RESTART 13
`define PCS_C_PWR_DN 10
`define PCS_C_XO_DIS 9
`define PCS_C_FORCE_X 8
`define PCS_C_AN_EN 6
`define PCS_C_SPD100 5
`define PCS_C_FULL 4

`define PCS_S_XVAR 15
`define PCS_S_POL 13
`define PCS_S_RXFC 12
`define PCS_S_TXFC 11
`define PCS_S_SPD 10
`define PCS_S_DUP 9
`define PCS_S_MDI 7
`define PCS_S_DONE 6
`define PCS_S_LINK 5
`define PCS_S_PAUSE 4
`define PCS_ADV_HI 3
`define PCS_BSEL_HI 5
`define PCS_LEDS_OFF 4'hf
`define PCS_XO_AUTO_RST 1'b1
`define PCS_E_LINK 0

`endif

// [inc/pcs_pkg.sv]
/*
 * Types for the port PHY control and status register bank.
 * Assumes pcs_defs.svh is on the include path.
 */
package pcs_pkg;
    typedef struct packed {
        logic [15:0] ctrl;
        logic xvar;
        logic [5:0] bank;
        logic link_prev;
        logic link_chg;
        logic restart;
        logic auto_x;
        logic force_x;
        logic [3:0] leds;
        logic [15:0] rdata;
    } pcs_state_t;
endpackage : pcs_pkg

// [dv/pcs_phy_model.sv]
/*
 * Far-side PHY status model for the register bank bench.
 * Assumes the bench sets the wanted line state on req.
 */
`timescale 1ns/1ps

module pcs_phy_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wanted state: pol, rx fc, tx fc, speed, duplex, mdi, done, link, pause, abilities
    input wire logic [12:0] req,
    // Status lines
    output logic [12:0] st
);
    // Lags one clock, so reads right after a change see the old state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= 13'h0000;
        end else begin
            st <= req;
        end
    end
endmodule : pcs_phy_model

// [dv/tb_top.sv]
/*
 * Self-checking bench for the port PHY control and status bank.
 * Assumes pcs_regs and pcs_phy_model are compiled first.
 */
`timescale 1ns/1ps

module tb_top;
    logic clk;
    logic rst;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [3:0] led_drive;
    logic [12:0] req;
    logic [12:0] st;
    logic [15:0] rdata;
    logic [16:0] outs;
    logic [12:0] pat [3] = '{13'h1fff, 13'h0aaa, 13'h1555};
    int err_total;
    int checked;

    pcs_phy_model phy (.clk(clk), .rst(rst), .req(req), .st(st));

    pcs_regs dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .polarity_rev(st[12]), .rx_fc_active(st[11]), .tx_fc_active(st[10]),
        .speed_100(st[9]), .duplex_full(st[8]), .mdi_status(st[7]),
        .negotiation_complete(st[6]), .link_good(st[5]), .partner_pause(st[4]),
        .partner_abil(st[3:0]), .led_drive(led_drive),
        .port_led_out_3(outs[16]), .port_led_out_2(outs[15]),
        .port_led_out_1(outs[14]), .port_led_out_0(outs[13]),
        .tx_disable(outs[12]), .power_down(outs[11]), .auto_negotiation(outs[10]),
        .forced_speed_100(outs[9]), .forced_duplex_full(outs[8]),
        .negotiation_restart(outs[7]), .advertise(outs[6:3]),
        .auto_crossover_en(outs[2]), .force_mdix(outs[1]), .crossover_variant_select(outs[0])
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {1'b0, exp}, {1'b0, rdata});
    endtask : rd_chk

    // Write then read with no idle cycle between the strobes
    task automatic wr_rd_chk(input string what, input logic [3:0] wa, input logic [15:0] d,
        input logic [3:0] ra, input logic [15:0] exp);
        @(posedge clk);
        wr <= 1'b1;
        addr <= wa;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= ra;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {1'b0, exp}, {1'b0, rdata});
    endtask : wr_rd_chk

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // Whole run is well under 200 cycles
    initial begin
        #20000;
        err_total++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        led_drive = 4'h5;
        req = 13'h0000;
        err_total = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset outputs", {4'h5, 6'b001110, 4'hf, 3'b101}, outs);
        wr_rd_chk("bank select", 4'he, 16'h0031, 4'he, 16'h0031);
        rd_chk("control reset", 4'h2, 16'h007f);
        wr_reg(4'h2, 16'he705);
        chk("control set", {4'hf, 6'b110001, 4'h5, 3'b011}, outs);
        @(posedge clk);
        #1;
        chk("restart pulse", 17'h00000, {16'h0000, outs[7]});
        rd_chk("control back", 4'h2, 16'hc705);
        @(posedge clk);
        led_drive <= 4'ha;
        wr_reg(4'h2, 16'h013a);
        chk("control clear", {4'ha, 6'b000110, 4'ha, 3'b101}, outs);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            req <= pat[i];
            repeat (2) @(posedge clk);
            rd_chk("status", 4'h4, {2'b10, pat[i][12:8], 1'b0, pat[i][7:0]});
        end
        rd_chk("link event", 4'h6, 16'h0001);
        wr_rd_chk("link event clear", 4'h6, 16'h0001, 4'h6, 16'h0000);
        wr_reg(4'h4, 16'h0000);
        chk("variant", 17'h00000, {16'h0000, outs[0]});
        rd_chk("status variant", 4'h4, {2'b00, pat[2][12:8], 1'b0, pat[2][7:0]});
        wr_rd_chk("reserved status", 4'he, 16'h0032, 4'h4, 16'h0000);
        wr_reg(4'h2, 16'h8000);
        chk("reserved write", {13'h0000, 4'ha}, {13'h0000, outs[16:13]});
        rd_chk("reserved bank select", 4'he, 16'h0032);
        wr_rd_chk("unmapped offset", 4'he, 16'h0031, 4'h8, 16'h0000);
        stop_test();
    end
endmodule : tb_top
